// *** src/event_pulse.sv ***
// Purpose: turn a detect level or a test strobe into a one-cycle pulse
// Assumes: inputs synchronous to the clock
// Notes: a level held high gives only one pulse
`timescale 1ns/1ps
module event_pulse (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic detect,
  input wire logic inject,
  output logic pulse
);

  logic seen;
  logic trigger;

  assign trigger = detect | inject;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seen <= 1'b0;
    end else begin
      seen <= trigger;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pulse <= 1'b0;
    end else begin
      pulse <= trigger & ~seen;
    end
  end

endmodule

// *** src/link_status_pkg.sv ***
// Purpose: shared constants and types of the link status and error report block
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes: link state codes are the fixed output encoding seen by the application
package link_status_pkg;

  // link training state codes
  localparam logic [4:0] LTS_DETECT_QUIET = 5'h00;
  localparam logic [4:0] LTS_DETECT_ACTIVE = 5'h01;
  localparam logic [4:0] LTS_POLL_ACTIVE = 5'h02;
  localparam logic [4:0] LTS_POLL_COMPLIANCE = 5'h03;
  localparam logic [4:0] LTS_POLL_SPEED = 5'h04;
  localparam logic [4:0] LTS_CFG_WIDTH_START = 5'h06;
  localparam logic [4:0] LTS_CFG_WIDTH_ACCEPT = 5'h07;
  localparam logic [4:0] LTS_CFG_LANE_ACCEPT = 5'h08;
  localparam logic [4:0] LTS_CFG_LANE_WAIT = 5'h09;
  localparam logic [4:0] LTS_CFG_COMPLETE = 5'h0a;
  localparam logic [4:0] LTS_CFG_IDLE = 5'h0b;
  localparam logic [4:0] LTS_REC_LOCK = 5'h0c;
  localparam logic [4:0] LTS_REC_CONFIG = 5'h0d;
  localparam logic [4:0] LTS_REC_IDLE = 5'h0e;
  localparam logic [4:0] LTS_L0 = 5'h0f;
  localparam logic [4:0] LTS_DISABLE = 5'h10;
  localparam logic [4:0] LTS_LOOP_ENTRY = 5'h11;
  localparam logic [4:0] LTS_LOOP_EXIT = 5'h12;
  localparam logic [4:0] LTS_HOT_RESET = 5'h14;
  localparam logic [4:0] LTS_REC_SPEED = 5'h1a;
  localparam logic [4:0] LTS_REC_EQ_PH0 = 5'h1b;
  localparam logic [4:0] LTS_REC_EQ_PH2 = 5'h1d;
  localparam logic [4:0] LTS_REC_EQ_PH3 = 5'h1e;
  localparam logic [4:0] LTS_REC_EQ_DONE = 5'h1f;

  // transmit parity error codes
  localparam logic [1:0] TX_ERR_NONE = 2'h0;
  localparam logic [1:0] TX_ERR_TL = 2'h2;
  localparam logic [1:0] TX_ERR_DLL = 2'h1;

  // advertised completion credit, zero means unlimited
  localparam logic [11:0] CREDIT_INF_DATA = 12'h000;
  localparam logic [7:0] CREDIT_INF_HDR = 8'h00;

  // register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_LINK = 8'h08;
  localparam logic [7:0] REG_CAPACITY = 8'h0c;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_COUNT = 8'h14;

  // status and mask bit positions
  localparam int ST_RX_PAR = 0;
  localparam int ST_TX_TL_PAR = 1;
  localparam int ST_TX_DLL_PAR = 2;
  localparam int ST_CPL_OVF = 3;
  localparam int ST_LINK_UP = 4;
  localparam int ST_LINK_DOWN = 5;
  localparam int ST_W = 6;
  localparam logic [ST_W-1:0] MASK_RESET = 6'h00;

  // control bits
  localparam int CTRL_INJ_RX = 0;
  localparam int CTRL_INJ_TX = 1;
  localparam int CTRL_IRQ_EN = 2;
  localparam logic CTRL_IRQ_EN_RESET = 1'b1;

  // field positions inside words
  localparam int CAP_DATA_LSB = 0;
  localparam int CAP_HDR_LSB = 16;
  localparam int CNT_RX_LSB = 0;
  localparam int CNT_TX_LSB = 8;
  localparam int CNT_W = 8;
  localparam int LINK_VALID_BIT = 8;

  typedef struct packed {
    logic rx_tlp;
    logic tx_tl;
    logic tx_dll;
    logic cpl_ovf;
  } core_err_t;

  typedef struct packed {
    logic [7:0] hdr;
    logic [11:0] data;
  } cpl_credit_t;

endpackage

// *** src/link_status_report.sv ***
// Purpose: link training state, parity error and completion capacity reporting
// Assumes: one clock core_clk at 200 MHz, async active-high rst, AHB-Lite slave
// Notes: status bits are sticky and clear on read; reads take one wait state
// Contract
// - output current training state on five bits; L0 01111, hot reset 10100
// - equalization phase 0, 2, 3 and done coded 11011, 11101, 11110, 11111
// - receive parity error pulses high for exactly one cycle
// - transmit layer parity error drives 2'b10 for one cycle
// - data link layer parity error later drives 2'b01 for one cycle
// - static twelve-bit count of 16-byte completion data units buffered
// - static eight-bit count of completion headers buffered
// - advertise unlimited completion data and header credit to partner
// - completion buffer overflow output asserted while the buffer overflows
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module link_status_report
  import link_status_pkg::*;
#(
  parameter logic [11:0] CPL_DATA_UNITS = 12'h100,
  parameter logic [7:0] CPL_HEADERS = 8'h40
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] trainer_state,
  input wire core_err_t core_err,
  output logic [4:0] link_state,
  output logic rx_parity_error,
  output logic [1:0] tx_parity_error,
  output cpl_credit_t completion_capacity,
  output cpl_credit_t advertised_credit,
  output logic cpl_overflow,
  output logic irq,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_RD_WAIT,
    BUS_RD_DATA
  } bus_state_t;

  function automatic logic legal_state(input logic [4:0] code);
    case (code)
      LTS_DETECT_QUIET, LTS_DETECT_ACTIVE, LTS_POLL_ACTIVE, LTS_POLL_COMPLIANCE,
      LTS_POLL_SPEED, LTS_CFG_WIDTH_START, LTS_CFG_WIDTH_ACCEPT, LTS_CFG_LANE_ACCEPT,
      LTS_CFG_LANE_WAIT, LTS_CFG_COMPLETE, LTS_CFG_IDLE, LTS_REC_LOCK,
      LTS_REC_CONFIG, LTS_REC_IDLE, LTS_L0, LTS_DISABLE, LTS_LOOP_ENTRY,
      LTS_LOOP_EXIT, LTS_HOT_RESET, LTS_REC_SPEED, LTS_REC_EQ_PH0,
      LTS_REC_EQ_PH2, LTS_REC_EQ_PH3, LTS_REC_EQ_DONE: legal_state = 1'b1;
      default: legal_state = 1'b0;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] value, input logic hit);
    if (hit && value != {CNT_W{1'b1}}) begin
      sat_inc = value + 1'b1;
    end else begin
      sat_inc = value;
    end
  endfunction

  bus_state_t bus_state;
  logic [7:0] bus_addr;
  logic addr_phase;
  logic wr_now;
  logic rd_now;

  logic [ST_W-1:0] status;
  logic [ST_W-1:0] next_status;
  logic [ST_W-1:0] status_set;
  logic [ST_W-1:0] status_clr;
  logic [ST_W-1:0] mask;
  logic irq_en;
  logic inj_rx;
  logic inj_tx;
  logic link_seen;
  logic [CNT_W-1:0] rx_err_count;
  logic [CNT_W-1:0] tx_err_count;
  logic [31:0] read_word;

  logic rx_pulse;
  logic tl_pulse;
  logic dll_pulse;
  logic ovf_pulse;
  logic dll_pending;
  logic link_up_evt;
  logic link_down_evt;

  // edge shaping of core error detects
  event_pulse rx_shaper (
    .core_clk(core_clk),
    .rst(rst),
    .detect(core_err.rx_tlp),
    .inject(inj_rx),
    .pulse(rx_pulse)
  );

  event_pulse tl_shaper (
    .core_clk(core_clk),
    .rst(rst),
    .detect(core_err.tx_tl),
    .inject(inj_tx),
    .pulse(tl_pulse)
  );

  event_pulse dll_shaper (
    .core_clk(core_clk),
    .rst(rst),
    .detect(core_err.tx_dll),
    .inject(1'b0),
    .pulse(dll_pulse)
  );

  event_pulse ovf_shaper (
    .core_clk(core_clk),
    .rst(rst),
    .detect(core_err.cpl_ovf),
    .inject(1'b0),
    .pulse(ovf_pulse)
  );

  // link training state, unknown codes keep the last good one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_state <= LTS_DETECT_QUIET;
    end else if (legal_state(trainer_state)) begin
      link_state <= trainer_state;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_seen <= 1'b0;
    end else if (legal_state(trainer_state)) begin
      link_seen <= 1'b1;
    end
  end

  assign link_up_evt = legal_state(trainer_state) && trainer_state == LTS_L0 && link_state != LTS_L0;
  assign link_down_evt = legal_state(trainer_state) && trainer_state != LTS_L0 && link_state == LTS_L0;

  // receive parity error output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_parity_error <= 1'b0;
    end else begin
      rx_parity_error <= rx_pulse;
    end
  end

  // transmit parity error: layer code first, link code one cycle apart
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_parity_error <= TX_ERR_NONE;
    end else if (tl_pulse) begin
      tx_parity_error <= TX_ERR_TL;
    end else if (dll_pulse || dll_pending) begin
      tx_parity_error <= TX_ERR_DLL;
    end else begin
      tx_parity_error <= TX_ERR_NONE;
    end
  end

  // a link-layer report that meets a layer report waits one cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dll_pending <= 1'b0;
    end else if (tl_pulse) begin
      dll_pending <= dll_pulse | dll_pending;
    end else begin
      dll_pending <= 1'b0;
    end
  end

  // completion buffer overflow level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cpl_overflow <= 1'b0;
    end else begin
      cpl_overflow <= core_err.cpl_ovf;
    end
  end

  // static capacity and unlimited advertised credit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      completion_capacity.data <= CPL_DATA_UNITS;
      completion_capacity.hdr <= CPL_HEADERS;
    end else begin
      completion_capacity.data <= CPL_DATA_UNITS;
      completion_capacity.hdr <= CPL_HEADERS;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      advertised_credit.data <= CREDIT_INF_DATA;
      advertised_credit.hdr <= CREDIT_INF_HDR;
    end else begin
      advertised_credit.data <= CREDIT_INF_DATA;
      advertised_credit.hdr <= CREDIT_INF_HDR;
    end
  end

  // bus slave: writes zero wait, reads one wait state
  assign addr_phase = hsel & htrans[1] & hready;
  assign hreadyout = (bus_state != BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign wr_now = (bus_state == BUS_WRITE);
  assign rd_now = (bus_state == BUS_RD_WAIT);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_state <= BUS_IDLE;
    end else begin
      case (bus_state)
        BUS_RD_WAIT: bus_state <= BUS_RD_DATA;
        BUS_IDLE, BUS_WRITE, BUS_RD_DATA: begin
          if (addr_phase) begin
            bus_state <= hwrite ? BUS_WRITE : BUS_RD_WAIT;
          end else begin
            bus_state <= BUS_IDLE;
          end
        end
        default: bus_state <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_addr <= 8'h00;
    end else if (addr_phase) begin
      bus_addr <= haddr[7:0];
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    read_word = 32'h0000_0000;
    case (bus_addr)
      REG_STATUS: read_word[ST_W-1:0] = status;
      REG_MASK: read_word[ST_W-1:0] = mask;
      REG_LINK: begin
        read_word[4:0] = link_state;
        read_word[LINK_VALID_BIT] = link_seen;
      end
      REG_CAPACITY: begin
        read_word[CAP_DATA_LSB +: 12] = completion_capacity.data;
        read_word[CAP_HDR_LSB +: 8] = completion_capacity.hdr;
      end
      REG_CTRL: read_word[CTRL_IRQ_EN] = irq_en;
      REG_COUNT: begin
        read_word[CNT_RX_LSB +: CNT_W] = rx_err_count;
        read_word[CNT_TX_LSB +: CNT_W] = tx_err_count;
      end
      default: read_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_now) begin
      hrdata <= read_word;
    end
  end

  // sticky status, an event in the clearing cycle survives
  always_comb begin
    status_set = '0;
    status_set[ST_RX_PAR] = rx_pulse;
    status_set[ST_TX_TL_PAR] = tl_pulse;
    status_set[ST_TX_DLL_PAR] = dll_pulse;
    status_set[ST_CPL_OVF] = ovf_pulse;
    status_set[ST_LINK_UP] = link_up_evt;
    status_set[ST_LINK_DOWN] = link_down_evt;
    status_clr = (rd_now && bus_addr == REG_STATUS) ? status : '0;
    next_status = (status & ~status_clr) | status_set;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask <= MASK_RESET;
    end else if (wr_now && bus_addr == REG_MASK) begin
      mask <= hwdata[ST_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_en <= CTRL_IRQ_EN_RESET;
    end else if (wr_now && bus_addr == REG_CTRL) begin
      irq_en <= hwdata[CTRL_IRQ_EN];
    end
  end

  // test strobes, self clearing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inj_rx <= 1'b0;
      inj_tx <= 1'b0;
    end else begin
      inj_rx <= wr_now && bus_addr == REG_CTRL && hwdata[CTRL_INJ_RX];
      inj_tx <= wr_now && bus_addr == REG_CTRL && hwdata[CTRL_INJ_TX];
    end
  end

  // saturating error counters, any write to REG_COUNT clears them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_err_count <= '0;
    end else if (wr_now && bus_addr == REG_COUNT) begin
      rx_err_count <= '0;
    end else begin
      rx_err_count <= sat_inc(rx_err_count, rx_pulse);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_err_count <= '0;
    end else if (wr_now && bus_addr == REG_COUNT) begin
      tx_err_count <= '0;
    end else begin
      tx_err_count <= sat_inc(tx_err_count, tl_pulse | dll_pulse);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_en & (|(next_status & mask));
    end
  end

endmodule

// *** tb/app_model.sv ***
// Purpose: application side that consumes the error and capacity outputs
// Assumes: same clock and reset as the block
// Notes: asks for a core reset after any parity error
`timescale 1ns/1ps
module app_model
  import link_status_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rx_parity_error,
  input wire logic [1:0] tx_parity_error,
  input wire cpl_credit_t completion_capacity,
  input wire logic [7:0] hdr_in_flight,
  output logic core_reset_req,
  output logic may_request
);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_reset_req <= 1'b0;
    end else begin
      core_reset_req <= rx_parity_error | (|tx_parity_error);
    end
  end
  // stop issuing reads once headers could overrun the buffer
  assign may_request = hdr_in_flight < completion_capacity.hdr;
endmodule

// *** tb/link_status_report_asserts.sv ***
// Purpose: assertions on link state, parity error, capacity and overflow outputs
// Assumes: bound to every link_status_report instance
// Notes: capacity parameters follow the bound instance
`timescale 1ns/1ps
module link_status_report_asserts
  import link_status_pkg::*;
#(
  parameter logic [11:0] CPL_DATA_UNITS = 12'h100,
  parameter logic [7:0] CPL_HEADERS = 8'h40
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] trainer_state,
  input wire core_err_t core_err,
  input wire logic [4:0] link_state,
  input wire logic rx_parity_error,
  input wire logic [1:0] tx_parity_error,
  input wire cpl_credit_t completion_capacity,
  input wire cpl_credit_t advertised_credit,
  input wire logic cpl_overflow
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  l0_code_a: assert property (trainer_state == 5'h0f |=> link_state == 5'h0f)
    else $error("link state not shown as L0");
  hot_reset_code_a: assert property (trainer_state == 5'h14 |=> link_state == 5'h14)
    else $error("link state not shown as hot reset");
  eq_code_a: assert property (trainer_state inside {5'h1b, 5'h1d, 5'h1e, 5'h1f} |=>
    link_state == $past(trainer_state)) else $error("equalization code not passed");
  rx_cause_a: assert property ($rose(core_err.rx_tlp) |-> ##2 rx_parity_error)
    else $error("receive parity pulse missing");
  rx_single_a: assert property (rx_parity_error |=> !rx_parity_error)
    else $error("receive parity pulse too long");
  tx_tl_a: assert property ($rose(core_err.tx_tl) |-> ##2 tx_parity_error == 2'b10 ##1
    tx_parity_error != 2'b10) else $error("transaction layer code wrong");
  tx_dll_a: assert property ($rose(core_err.tx_dll) && !$rose(core_err.tx_tl) |-> ##2
    tx_parity_error == 2'b01 ##1 tx_parity_error != 2'b01) else $error("link layer code wrong");
  tx_order_a: assert property ($rose(core_err.tx_dll) && $rose(core_err.tx_tl) |-> ##2
    tx_parity_error == 2'b10 ##1 tx_parity_error == 2'b01) else $error("tx code order wrong");
  tx_legal_a: assert property (tx_parity_error != 2'b11)
    else $error("tx code both bits");
  cap_static_a: assert property (completion_capacity == {CPL_HEADERS, CPL_DATA_UNITS})
    else $error("capacity not static");
  credit_inf_a: assert property (advertised_credit == {CREDIT_INF_HDR, CREDIT_INF_DATA})
    else $error("credit not unlimited");
  ovf_follow_a: assert property (cpl_overflow == $past(core_err.cpl_ovf))
    else $error("overflow not following buffer");
endmodule

bind link_status_report link_status_report_asserts #(
  .CPL_DATA_UNITS(CPL_DATA_UNITS),
  .CPL_HEADERS(CPL_HEADERS)
) chk (
  .core_clk(core_clk),
  .rst(rst),
  .trainer_state(trainer_state),
  .core_err(core_err),
  .link_state(link_state),
  .rx_parity_error(rx_parity_error),
  .tx_parity_error(tx_parity_error),
  .completion_capacity(completion_capacity),
  .advertised_credit(advertised_credit),
  .cpl_overflow(cpl_overflow)
);

// *** tb/test_link_status_report.sv ***
// Purpose: self-checking bench for the link status and error report block
// Assumes: AHB-Lite master tasks, one clock
// Notes: results are queued by the driver and matched by a monitor
`timescale 1ns/1ps
module test_link_status_report;
  import link_status_pkg::*;
  localparam logic [11:0] CAP_D = 12'h2a5;
  localparam logic [7:0] CAP_H = 8'h3c;
  localparam logic [4:0] CODES [0:23] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07, 5'h08,
    5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h14, 5'h1a, 5'h1b,
    5'h1d, 5'h1e, 5'h1f};
  logic core_clk, rst, hsel, hwrite, rx_parity_error, cpl_overflow, irq, hreadyout, hresp;
  logic [4:0] trainer_state, link_state;
  logic [1:0] htrans, tx_parity_error;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  core_err_t core_err;
  cpl_credit_t completion_capacity, advertised_credit;
  logic [31:0] exp_q [$];
  logic rd_pend = 1'b0;
  logic reset_due = 1'b0;
  logic core_reset_req, may_request;
  logic [7:0] hdr_in_flight;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int k;

  link_status_report #(.CPL_DATA_UNITS(CAP_D), .CPL_HEADERS(CAP_H)) DUT (
    .core_clk(core_clk), .rst(rst), .trainer_state(trainer_state), .core_err(core_err),
    .link_state(link_state), .rx_parity_error(rx_parity_error), .tx_parity_error(tx_parity_error),
    .completion_capacity(completion_capacity), .advertised_credit(advertised_credit),
    .cpl_overflow(cpl_overflow), .irq(irq), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));
  app_model partner (.core_clk(core_clk), .rst(rst), .rx_parity_error(rx_parity_error),
    .tx_parity_error(tx_parity_error), .completion_capacity(completion_capacity),
    .hdr_in_flight(hdr_in_flight), .core_reset_req(core_reset_req), .may_request(may_request));

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task stop_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task take(input string name, input logic [31:0] seen);
    if (exp_q.size() == 0) check(name, seen, 32'hx);
    else check(name, seen, exp_q.pop_front());
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask
  task err(input logic [3:0] m, input int hold);
    @(posedge core_clk);
    core_err <= m;
    repeat (hold) @(posedge core_clk);
    core_err <= 4'h0;
    repeat (5) @(posedge core_clk);
    #1;
  endtask
  task set_state(input logic [4:0] code, input logic [4:0] exp);
    @(posedge core_clk);
    trainer_state <= code;
    @(posedge core_clk);
    #1 check("link_state", 32'(link_state), 32'(exp));
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  // monitor samples the values that stood during the cycle just ended
  always @(posedge core_clk) begin
    if (!rst) begin
      if (rd_pend && hreadyout) begin
        rd_pend = 1'b0;
        take("hrdata", hrdata);
        check("hresp", 32'(hresp), 32'h0);
      end
      if (hsel && htrans[1] && hreadyout && !hwrite) rd_pend = 1'b1;
      if (rx_parity_error === 1'b1) take("rx_parity_error", 32'h100);
      if (tx_parity_error !== 2'b00) take("tx_parity_error", {30'h80, tx_parity_error});
      // application asks for a core reset the cycle after any parity report
      if (reset_due) check("core_reset_req", 32'(core_reset_req), 32'h1);
      reset_due = rx_parity_error === 1'b1 || tx_parity_error !== 2'b00;
    end
  end

  initial begin
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, trainer_state} = '0;
    hdr_in_flight = 8'h00;
    hsize = 3'h2;
    core_err = 4'h0;
    void'($urandom(91181));
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd(REG_CAPACITY, {8'h0, CAP_H, 4'h0, CAP_D});
    rd(REG_MASK, 32'h0);
    rd(REG_CTRL, 32'h4);
    rd(REG_STATUS, 32'h0);
    rd(8'h3c, 32'h0);
    check("capacity", 32'(completion_capacity), 32'({CAP_H, CAP_D}));
    check("credit", 32'(advertised_credit), 32'h0);
    hdr_in_flight <= CAP_H - 8'h01;
    @(posedge core_clk);
    #1 check("may_request", 32'(may_request), 32'h1);
    hdr_in_flight <= CAP_H;
    @(posedge core_clk);
    #1 check("may_request", 32'(may_request), 32'h0);
    foreach (CODES[i]) set_state(CODES[i], CODES[i]);
    set_state(5'h05, 5'h1f);
    repeat (16) begin
      k = $urandom_range(23);
      set_state(CODES[k], CODES[k]);
    end
    rd(REG_LINK, 32'h100 | CODES[k]);
    rd(REG_STATUS, 32'h30);
    bus(1'b1, REG_MASK, 32'h1);
    exp_q.push_back(32'h100);
    err(4'h8, 3);
    check("irq", 32'(irq), 32'h1);
    rd(REG_STATUS, 32'h1);
    repeat (2) @(posedge core_clk);
    #1 check("irq", 32'(irq), 32'h0);
    exp_q.push_back(32'h202);
    exp_q.push_back(32'h201);
    err(4'h6, 1);
    exp_q.push_back(32'h201);
    err(4'h2, 1);
    exp_q.push_back(32'h202);
    err(4'h4, 1);
    check("irq", 32'(irq), 32'h0);
    @(posedge core_clk);
    core_err <= 4'h1;
    @(posedge core_clk);
    #1 check("cpl_overflow", 32'(cpl_overflow), 32'h1);
    @(posedge core_clk);
    core_err <= 4'h0;
    @(posedge core_clk);
    #1 check("cpl_overflow", 32'(cpl_overflow), 32'h0);
    rd(REG_STATUS, 32'h0e);
    // tl and dll reports in one cycle count once
    rd(REG_COUNT, 32'h0301);
    bus(1'b1, REG_COUNT, 32'h0);
    rd(REG_COUNT, 32'h0);
    exp_q.push_back(32'h100);
    bus(1'b1, REG_CTRL, 32'h5);
    repeat (6) @(posedge core_clk);
    exp_q.push_back(32'h202);
    bus(1'b1, REG_CTRL, 32'h6);
    repeat (6) @(posedge core_clk);
    rd(REG_CTRL, 32'h4);
    rd(REG_COUNT, 32'h0101);
    bus(1'b1, 8'h3c, 32'hffff_ffff);
    rd(8'h3c, 32'h0);
    repeat (4) @(posedge core_clk);
    check("queue", exp_q.size(), 32'h0);
    stop_test();
  end
endmodule
